// ===== core/ouv_monitor.sv
// undervoltage warning, fault and fault response with restart_wait_period retry
// assumes command strobes, sense data and pwm tick all come from logic on sys_clk
`timescale 1ns/1ps
module ouv_monitor (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   input  wire logic [15:0] cmd_wdata,
   output logic      [15:0] cmd_rdata,
   output logic             cmd_rvalid,
   input  wire logic [15:0] vout_sense,
   input  wire logic [15:0] vout_target,
   input  wire logic        vout_relative,
   input  wire logic        pwm_tick,
   input  wire logic [15:0] soft_start_rise_time,
   input  wire logic        soft_start_done,
   input  wire logic        output_enabled,
   input  wire logic        other_shutdown_fault,
   input  wire logic        clear_faults,
   output logic             shutdown_req,
   output logic             restart_req,
   output logic             status_vout,
   output logic             status_nota,
   output logic             low_warning_flag,
   output logic             low_fault_flag,
   output logic             invalid_data_flag,
   output logic             host_alert,
   output logic             latched_off
);
   logic [15:0] warn_word_q, warn_word_d, fault_word_q, fault_word_d;
   logic [3:0]  warn_idx_q, warn_idx_d, fault_idx_q, fault_idx_d;
   logic [7:0]  action_q, action_d;
   logic [15:0] rdata_q, rdata_d;
   logic        rvalid_q, rvalid_d;
   logic        vout_q, vout_d, nota_q, nota_d, warn_q, warn_d, fault_q, fault_d;
   logic        inval_q, inval_d, alert_q, alert_d;
   logic        warn_seen_q, fault_seen_q;
   logic [3:0]  map_warn_idx, map_fault_idx;
   logic        map_warn_ok, map_fault_ok;
   logic [27:0] sense_pm, warn_thr, fault_thr;
   logic        under_warn, under_fault, warn_event, fault_event;

   ouv_step_map #(
      .MIN_PM  (ouv_pkg::WARN_MIN_PM),
      .STEP_PM (ouv_pkg::WARN_STEP_PM),
      .COUNT   (ouv_pkg::WARN_STEPS)
   ) u_warn_map (
      .value    (cmd_wdata),
      .target   (vout_target),
      .relative (vout_relative),
      .step_idx (map_warn_idx),
      .in_range (map_warn_ok)
   );

   // fault limit is always absolute
   ouv_step_map #(
      .MIN_PM  (ouv_pkg::FAULT_MIN_PM),
      .STEP_PM (ouv_pkg::FAULT_STEP_PM),
      .COUNT   (ouv_pkg::FAULT_STEPS)
   ) u_fault_map (
      .value    (cmd_wdata),
      .target   (vout_target),
      .relative (1'b0),
      .step_idx (map_fault_idx),
      .in_range (map_fault_ok)
   );

   // thresholds follow the live target and stored step, so writes act at once
   assign sense_pm  = 28'(vout_sense) * 28'(ouv_pkg::PM_FULL);
   assign warn_thr  = 28'(vout_target) * 28'(ouv_pkg::WARN_MIN_PM
                      + int'(warn_idx_q) * ouv_pkg::WARN_STEP_PM);
   assign fault_thr = 28'(vout_target) * 28'(ouv_pkg::FAULT_MIN_PM
                      + int'(fault_idx_q) * ouv_pkg::FAULT_STEP_PM);
   assign under_warn  = sense_pm < warn_thr;
   assign under_fault = sense_pm < fault_thr;
   // only a fresh crossing raises an event, not a level that stays low
   assign warn_event  = under_warn && !warn_seen_q;
   assign fault_event = under_fault && !fault_seen_q;

   always_comb begin
      warn_word_d  = warn_word_q;
      fault_word_d = fault_word_q;
      warn_idx_d   = warn_idx_q;
      fault_idx_d  = fault_idx_q;
      action_d     = action_q;
      rdata_d      = rdata_q;
      rvalid_d     = 1'b0;
      vout_d       = vout_q;
      nota_d       = nota_q;
      warn_d       = warn_q;
      fault_d      = fault_q;
      inval_d      = inval_q;
      if (clear_faults) begin
         vout_d  = 1'b0;
         nota_d  = 1'b0;
         warn_d  = 1'b0;
         fault_d = 1'b0;
         inval_d = 1'b0;
      end
      if (cmd_wr) begin
         unique case (cmd_code)
            ouv_pkg::CMD_WARN_LIMIT: begin
               if (map_warn_ok) begin
                  warn_word_d = cmd_wdata;
                  warn_idx_d  = map_warn_idx;
               end else begin
                  inval_d = 1'b1;
               end
            end
            ouv_pkg::CMD_FAULT_LIMIT: begin
               if (map_fault_ok) begin
                  fault_word_d = cmd_wdata;
                  fault_idx_d  = map_fault_idx;
               end else begin
                  inval_d = 1'b1;
               end
            end
            ouv_pkg::CMD_FAULT_ACTION: begin
               if (cmd_wdata[ouv_pkg::ACT_SEL_HI:ouv_pkg::ACT_SEL_LO] != ouv_pkg::SEL_INVALID) begin
                  action_d = cmd_wdata[7:0];
               end else begin
                  inval_d = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (cmd_rd) begin
         unique case (cmd_code)
            ouv_pkg::CMD_WARN_LIMIT: begin
               rdata_d  = warn_word_q;
               rvalid_d = 1'b1;
            end
            ouv_pkg::CMD_FAULT_LIMIT: begin
               rdata_d  = fault_word_q;
               rvalid_d = 1'b1;
            end
            ouv_pkg::CMD_FAULT_ACTION: begin
               rdata_d  = {8'h00, action_q};
               rvalid_d = 1'b1;
            end
            default: ;
         endcase
      end
      // sets come last so an event in the clearing cycle is kept
      if (warn_event) begin
         vout_d = 1'b1;
         warn_d = 1'b1;
      end
      if (fault_event) begin
         nota_d  = 1'b1;
         vout_d  = 1'b1;
         fault_d = 1'b1;
      end
      alert_d = vout_d || nota_d || warn_d || fault_d || inval_d;
   end

   // target changes never touch the stored words, only the host does
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         warn_word_q  <= ouv_pkg::WARN_WORD_RST;
         fault_word_q <= ouv_pkg::FAULT_WORD_RST;
         warn_idx_q   <= ouv_pkg::WARN_IDX_RST;
         fault_idx_q  <= ouv_pkg::FAULT_IDX_RST;
         action_q     <= ouv_pkg::ACTION_RST;
         rdata_q      <= 16'h0000;
         rvalid_q     <= 1'b0;
         vout_q       <= 1'b0;
         nota_q       <= 1'b0;
         warn_q       <= 1'b0;
         fault_q      <= 1'b0;
         inval_q      <= 1'b0;
         alert_q      <= 1'b0;
         warn_seen_q  <= 1'b0;
         fault_seen_q <= 1'b0;
      end else if (clk_en) begin
         warn_word_q  <= warn_word_d;
         fault_word_q <= fault_word_d;
         warn_idx_q   <= warn_idx_d;
         fault_idx_q  <= fault_idx_d;
         action_q     <= action_d;
         rdata_q      <= rdata_d;
         rvalid_q     <= rvalid_d;
         vout_q       <= vout_d;
         nota_q       <= nota_d;
         warn_q       <= warn_d;
         fault_q      <= fault_d;
         inval_q      <= inval_d;
         alert_q      <= alert_d;
         warn_seen_q  <= under_warn;
         fault_seen_q <= under_fault;
      end
   end

   // fault response sequencer
   ouv_pkg::ouv_state_e state_q, state_d;
   logic [18:0] cnt_q, cnt_d;
   logic [2:0]  retry_q, retry_d;
   logic        shut_q, shut_d, restart_q, restart_d, latched_q;
   logic [1:0]  sel;
   logic [2:0]  retry_lim, dly_code;
   logic [3:0]  dly_clks;
   logic [18:0] restart_wait_period_len;
   logic        cnt_last_dly, cnt_last_hic, cnt_last_rise, shut_class;

   assign sel       = action_q[ouv_pkg::ACT_SEL_HI:ouv_pkg::ACT_SEL_LO];
   assign retry_lim = action_q[ouv_pkg::ACT_RETRY_HI:ouv_pkg::ACT_RETRY_LO];
   assign dly_code  = action_q[ouv_pkg::ACT_DELAY_HI:ouv_pkg::ACT_DELAY_LO];
   assign dly_clks  = (dly_code >= ouv_pkg::DLY_LONG_FIRST) ? ouv_pkg::DLY_CLKS_LONG :
                      (dly_code >= ouv_pkg::DLY_MID_FIRST)  ? ouv_pkg::DLY_CLKS_MID :
                      ouv_pkg::DLY_CLKS_SHORT;
   // code 0 gives one rise time like code 1
   assign restart_wait_period_len = 19'(soft_start_rise_time)
                       * 19'((dly_code == 3'h0) ? 3'h1 : dly_code);
   assign cnt_last_dly  = (cnt_q + 19'h1) >= 19'(dly_clks);
   assign cnt_last_hic  = (cnt_q + 19'h1) >= restart_wait_period_len;
   assign cnt_last_rise = (cnt_q + 19'h1) >= 19'(soft_start_rise_time);
   assign shut_class = other_shutdown_fault
                       || (under_fault && (sel == ouv_pkg::SEL_DELAYED
                                           || sel == ouv_pkg::SEL_IMMEDIATE));

   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      retry_d   = retry_q;
      shut_d    = shut_q;
      restart_d = 1'b0;
      unique case (state_q)
         ouv_pkg::ST_RUN: begin
            shut_d  = 1'b0;
            cnt_d   = 19'h0;
            if (!output_enabled) begin
               retry_d = 3'h0;
            end else if (fault_event && sel == ouv_pkg::SEL_DELAYED) begin
               state_d = ouv_pkg::ST_DELAY;
            end else if (fault_event && sel == ouv_pkg::SEL_IMMEDIATE) begin
               state_d = ouv_pkg::ST_SHUT;
               shut_d  = 1'b1;
            end
         end
         ouv_pkg::ST_DELAY: begin
            if (!output_enabled || !under_fault) begin
               state_d = ouv_pkg::ST_RUN;
            end else if (pwm_tick && cnt_last_dly) begin
               state_d = ouv_pkg::ST_SHUT;
               shut_d  = 1'b1;
            end else if (pwm_tick) begin
               cnt_d = cnt_q + 19'h1;
            end
         end
         ouv_pkg::ST_SHUT: begin
            shut_d = 1'b1;
            cnt_d  = 19'h0;
            if (retry_lim == ouv_pkg::RETRY_LATCH
                || (retry_lim != ouv_pkg::RETRY_FOREVER && retry_q >= retry_lim)) begin
               state_d = ouv_pkg::ST_LATCHED;
            end else begin
               state_d = ouv_pkg::ST_RESTART_WAIT_PERIOD;
            end
         end
         ouv_pkg::ST_RESTART_WAIT_PERIOD: begin
            if (!output_enabled) begin
               state_d = ouv_pkg::ST_RUN;
            end else if (pwm_tick && cnt_last_hic) begin
               state_d   = ouv_pkg::ST_RAMP;
               shut_d    = 1'b0;
               restart_d = 1'b1;
               retry_d   = (retry_q == 3'h7) ? retry_q : retry_q + 3'h1;
            end else if (pwm_tick) begin
               cnt_d = cnt_q + 19'h1;
            end
         end
         ouv_pkg::ST_RAMP: begin
            cnt_d = 19'h0;
            if (!output_enabled) begin
               state_d = ouv_pkg::ST_RUN;
            end else if (other_shutdown_fault) begin
               state_d = ouv_pkg::ST_SHUT;
               shut_d  = 1'b1;
            end else if (soft_start_done) begin
               state_d = ouv_pkg::ST_CONFIRM;
            end
         end
         ouv_pkg::ST_CONFIRM: begin
            if (!output_enabled) begin
               state_d = ouv_pkg::ST_RUN;
            end else if (shut_class) begin
               state_d = ouv_pkg::ST_SHUT;
               shut_d  = 1'b1;
            end else if (pwm_tick && cnt_last_rise) begin
               state_d = ouv_pkg::ST_RUN;
               retry_d = 3'h0;
            end else if (pwm_tick) begin
               cnt_d = cnt_q + 19'h1;
            end
         end
         ouv_pkg::ST_LATCHED: begin
            shut_d = 1'b1;
            if (!output_enabled) begin
               state_d = ouv_pkg::ST_RUN;
               retry_d = 3'h0;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q   <= ouv_pkg::ST_RUN;
         cnt_q     <= 19'h0;
         retry_q   <= 3'h0;
         shut_q    <= 1'b0;
         restart_q <= 1'b0;
         latched_q <= 1'b0;
      end else if (clk_en) begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         retry_q   <= retry_d;
         shut_q    <= shut_d;
         restart_q <= restart_d;
         latched_q <= state_d == ouv_pkg::ST_LATCHED;
      end
   end

   assign cmd_rdata         = rdata_q;
   assign cmd_rvalid        = rvalid_q;
   assign shutdown_req      = shut_q;
   assign restart_req       = restart_q;
   assign status_vout       = vout_q;
   assign status_nota       = nota_q;
   assign low_warning_flag  = warn_q;
   assign low_fault_flag    = fault_q;
   assign invalid_data_flag = inval_q;
   assign host_alert        = alert_q;
   assign latched_off       = latched_q;

   chk_warn_flags: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && warn_event |=> low_warning_flag && status_vout)
      else $error("warning crossing did not set flags");
   chk_fault_flags: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && fault_event |=> status_nota && status_vout && low_fault_flag ##1 host_alert)
      else $error("fault did not set flags and alert");
   chk_bad_action: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && cmd_wr && cmd_code == ouv_pkg::CMD_FAULT_ACTION && cmd_wdata[7:6] == 2'h3
      |=> invalid_data_flag && $stable(action_q))
      else $error("invalid action code accepted");
   chk_limit_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !cmd_wr |=> $stable(warn_word_q) && $stable(fault_word_q))
      else $error("limit word changed without a write");
   chk_action_read: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && cmd_rd && cmd_code == ouv_pkg::CMD_FAULT_ACTION
      |=> cmd_rvalid && cmd_rdata == {8'h00, $past(action_q)})
      else $error("action readback wrong");
   chk_shut_now: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && state_q == ouv_pkg::ST_RUN && output_enabled && fault_event
      && sel == ouv_pkg::SEL_IMMEDIATE |=> shutdown_req)
      else $error("immediate shutdown missing");
   chk_ignore_run: assert property (@(posedge sys_clk) disable iff (!resetn)
      state_q == ouv_pkg::ST_RUN && sel == ouv_pkg::SEL_IGNORE |=> !shutdown_req)
      else $error("ignored fault shut the output");
   chk_latch_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && state_q == ouv_pkg::ST_SHUT && retry_lim == 3'h0 |=> latched_off)
      else $error("zero retry did not latch off");
   chk_retry_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && state_q == ouv_pkg::ST_CONFIRM && output_enabled && !shut_class
      && pwm_tick && cnt_last_rise |=> retry_q == 3'h0 && state_q == ouv_pkg::ST_RUN)
      else $error("successful restart kept retry count");
endmodule // ouv_monitor

// ===== core/ouv_step_map.sv
// maps a written limit word onto a supported threshold step, rounding down
// assumes value and target in the same units; relative words are per-mille of target
`timescale 1ns/1ps
module ouv_step_map #(
   parameter int MIN_PM  = 600,
   parameter int STEP_PM = 25,
   parameter int COUNT   = 15
) (
   input  wire logic [15:0] value,
   input  wire logic [15:0] target,
   input  wire logic        relative,
   output logic      [3:0]  step_idx,
   output logic             in_range
);
   logic [COUNT:0] ge;

   // one comparison per supported step plus one past the top
   for (genvar i = 0; i <= COUNT; i++) begin : g_step
      localparam logic [9:0] THR = 10'(MIN_PM + i * STEP_PM);
      logic [27:0] lhs;
      logic [27:0] rhs;
      assign lhs   = relative ? 28'(value) : 28'(value) * 28'(ouv_pkg::PM_FULL);
      assign rhs   = relative ? 28'(THR) : 28'(target) * 28'(THR);
      assign ge[i] = lhs >= rhs;
   end

   always_comb begin
      step_idx = 4'h0;
      for (int k = 1; k < COUNT; k++) begin
         if (ge[k]) begin
            step_idx = 4'(k);
         end
      end
      in_range = ge[0] && !ge[COUNT];
   end
endmodule // ouv_step_map

// ===== pkg/ouv_pkg.sv
// constants, field layout and state codes for the output undervoltage monitor
// assumes one 125 MHz clock; the command port and the pwm tick share that clock
// Functional notes
// - the warning limit is a 16-bit word read and written whole, taken as relative or absolute.
// - a fresh crossing below the warning threshold sets the summary, warning and alert flags.
// - a new target in absolute format leaves the stored warning and fault words untouched.
// - the warning threshold is a step from 84% to 97% of target in 1% steps, rounded down.
// - the fault limit is a 16-bit absolute word, and output below it raises a fault.
// - the fault threshold is a step from 60% to 95% of target in 2.5% steps, rounded down.
// - an unsupported write is refused, sets the invalid-data flag and alerts the host.
// - a fault sets the none-of-the-above, summary and fault flags and alerts the host.
// - action bits 7:6 choose ignore, shut down after delay, shut down at once or invalid.
// - restart bits 5:3 give latch off, one to six restart_wait_period retries, or endless retries.
// - delay bits 2:0 give 3, 5 or 9 switching clocks and a restart_wait_period of 1 to 7 rise times.
// - the action register is one byte, every bit readable and writable.
// - a restart succeeds, clearing the retry count, after one clean rise time past the ramp.
package ouv_pkg;
   localparam logic [7:0]  CMD_WARN_LIMIT   = 8'h43;
   localparam logic [7:0]  CMD_FAULT_LIMIT  = 8'h44;
   localparam logic [7:0]  CMD_FAULT_ACTION = 8'h45;
   localparam int          ACT_SEL_HI       = 7;
   localparam int          ACT_SEL_LO       = 6;
   localparam int          ACT_RETRY_HI     = 5;
   localparam int          ACT_RETRY_LO     = 3;
   localparam int          ACT_DELAY_HI     = 2;
   localparam int          ACT_DELAY_LO     = 0;
   localparam logic [1:0]  SEL_IGNORE       = 2'h0;
   localparam logic [1:0]  SEL_DELAYED      = 2'h1;
   localparam logic [1:0]  SEL_IMMEDIATE    = 2'h2;
   localparam logic [1:0]  SEL_INVALID      = 2'h3;
   localparam logic [2:0]  RETRY_LATCH      = 3'h0;
   localparam logic [2:0]  RETRY_FOREVER    = 3'h7;
   localparam logic [3:0]  DLY_CLKS_SHORT   = 4'h3;
   localparam logic [3:0]  DLY_CLKS_MID     = 4'h5;
   localparam logic [3:0]  DLY_CLKS_LONG    = 4'h9;
   localparam logic [2:0]  DLY_MID_FIRST    = 3'h2;
   localparam logic [2:0]  DLY_LONG_FIRST   = 3'h5;
   // thresholds in per-mille of target
   localparam int          PM_FULL          = 1000;
   localparam int          WARN_MIN_PM      = 840;
   localparam int          WARN_STEP_PM     = 10;
   localparam int          WARN_STEPS       = 14;
   localparam int          FAULT_MIN_PM     = 600;
   localparam int          FAULT_STEP_PM    = 25;
   localparam int          FAULT_STEPS      = 15;
   localparam logic [15:0] WARN_WORD_RST    = 16'h0000;
   localparam logic [15:0] FAULT_WORD_RST   = 16'h0000;
   localparam logic [3:0]  WARN_IDX_RST     = 4'h0;
   localparam logic [3:0]  FAULT_IDX_RST    = 4'h0;
   localparam logic [7:0]  ACTION_RST       = 8'h80;
   typedef enum logic [6:0] {
      ST_RUN     = 7'h01,
      ST_DELAY   = 7'h02,
      ST_SHUT    = 7'h04,
      ST_RESTART_WAIT_PERIOD  = 7'h08,
      ST_RAMP    = 7'h10,
      ST_CONFIRM = 7'h20,
      ST_LATCHED = 7'h40
   } ouv_state_e;
endpackage

// ===== testbench/output_undervoltage_monitor_tb_top.sv
// self-checking bench for the undervoltage monitor
// assumes one 125 MHz clock; stage model supplies tick and ramp completion
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("unexpected %s exp %h got %h", nm, ex, got); end end
module output_undervoltage_monitor_tb_top;
   logic        sys_clk, resetn, cmd_wr, cmd_rd, vout_relative, output_enabled, clear_faults;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata, vout_sense, vout_target;
   logic        cmd_rvalid, pwm_tick, soft_start_done, shutdown_req, restart_req;
   logic        status_vout, status_nota, low_warning_flag, low_fault_flag;
   logic        invalid_data_flag, host_alert, latched_off;
   int          fail_count = 0;
   int          n_checks   = 0;
   int          n;
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   ouv_monitor DUT (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .cmd_code(cmd_code),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
      .cmd_rvalid(cmd_rvalid), .vout_sense(vout_sense), .vout_target(vout_target),
      .vout_relative(vout_relative), .pwm_tick(pwm_tick), .soft_start_rise_time(16'h0004),
      .soft_start_done(soft_start_done), .output_enabled(output_enabled),
      .other_shutdown_fault(1'b0), .clear_faults(clear_faults), .shutdown_req(shutdown_req),
      .restart_req(restart_req), .status_vout(status_vout), .status_nota(status_nota),
      .low_warning_flag(low_warning_flag), .low_fault_flag(low_fault_flag),
      .invalid_data_flag(invalid_data_flag), .host_alert(host_alert),
      .latched_off(latched_off));
   ouv_stage_model stage (.sys_clk(sys_clk), .resetn(resetn), .restart_req(restart_req),
      .shutdown_req(shutdown_req), .pwm_tick(pwm_tick), .soft_start_done(soft_start_done));
   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      cmd_code = c; cmd_wdata = d; cmd_wr = 1'b1;
      step(1);
      cmd_wr = 1'b0;
      // one idle edge so a following request never sets the strobe twice in one step
      step(1);
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] ex);
      cmd_code = c; cmd_rd = 1'b1;
      step(1);
      cmd_rd = 1'b0;
      `CHK("rvalid", 1'b1, cmd_rvalid)
      `CHK("rdata", ex, cmd_rdata)
      step(1);
   endtask
   task automatic clr();
      clear_faults = 1'b1;
      step(1);
      clear_faults = 1'b0;
      step(2);
   endtask
   // bounded wait for shutdown (0) or restart (1), n counts the cycles spent
   task automatic wait_hi(input int which, input int lim);
      n = 0;
      while ((which != 0 ? restart_req : shutdown_req) !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
   endtask
   task automatic t_regs();
      rd_chk(8'h45, 16'h0080);
      rd_chk(8'h43, 16'h0000);
      rd_chk(8'h44, 16'h0000);
      wr(8'h45, 16'h0093);
      rd_chk(8'h45, 16'h0093);
      wr(8'h45, 16'h00C0);
      `CHK("invalid", 1'b1, invalid_data_flag)
      step(1);
      `CHK("alert", 1'b1, host_alert)
      rd_chk(8'h45, 16'h0093);
   endtask
   task automatic t_limits();
      clr();
      wr(8'h43, 16'h0384);
      rd_chk(8'h43, 16'h0384);
      wr(8'h44, 16'h0320);
      rd_chk(8'h44, 16'h0320);
      `CHK("no invalid", 1'b0, invalid_data_flag)
      wr(8'h44, 16'h01F4);
      `CHK("fault range", 1'b1, invalid_data_flag)
      vout_target = 16'h04B0;
      step(2);
      rd_chk(8'h44, 16'h0320);
      vout_target = 16'h03E8;
      clr();
   endtask
   task automatic t_warn();
      vout_sense = 16'h0352;
      step(2);
      `CHK("warn", 1'b1, low_warning_flag)
      `CHK("vout", 1'b1, status_vout)
      `CHK("no fault", 1'b0, low_fault_flag)
      step(1);
      `CHK("alert", 1'b1, host_alert)
   endtask
   task automatic t_latch();
      wr(8'h45, 16'h0080);
      clr();
      wr(8'h44, 16'h0384); // limit now above the held 850 sense
      wait_hi(0, 4);
      `CHK("live shut", 1'b1, shutdown_req)
      `CHK("nota", 1'b1, status_nota)
      `CHK("fault", 1'b1, low_fault_flag)
      step(2);
      `CHK("latch", 1'b1, latched_off)
      output_enabled = 1'b0;
      step(2);
      `CHK("unlatch", 1'b0, latched_off)
      vout_sense = 16'h03E8;
      wr(8'h44, 16'h0320);
      output_enabled = 1'b1;
      step(2);
   endtask
   task automatic t_retry();
      wr(8'h45, 16'h0048); // delayed, one retry, shortest delay
      clr();
      vout_sense = 16'h02BC;
      wait_hi(0, 30);
      `CHK("delay ok", 1'b1, (n >= 8) && (n <= 17))
      wait_hi(1, 40);
      `CHK("restart_wait_period", 1'b1, (n >= 12) && (n <= 22))
      vout_sense = 16'h03E8;
      step(60);
      `CHK("recovered", 1'b0, shutdown_req)
      `CHK("not latched", 1'b0, latched_off)
      // a second fault only restarts if the success above cleared the count
      wr(8'h45, 16'h004A);
      vout_sense = 16'h02BC;
      wait_hi(0, 40);
      `CHK("mid delay", 1'b1, (n >= 16) && (n <= 25))
      wait_hi(1, 50);
      `CHK("retry cleared", 1'b1, restart_req)
      `CHK("mid restart_wait_period", 1'b1, (n >= 28) && (n <= 36))
      vout_sense = 16'h03E8;
      step(60);
   endtask
   task automatic t_ignore();
      wr(8'h45, 16'h0000);
      wr(8'h43, 16'h03E8); // 100% is past the top warning step
      `CHK("warn range", 1'b1, invalid_data_flag)
      rd_chk(8'h43, 16'h0384);
      clr();
      vout_sense = 16'h02BC;
      step(20);
      `CHK("ignored", 1'b0, shutdown_req)
      `CHK("ign fault", 1'b1, low_fault_flag)
      vout_sense = 16'h03E8;
      step(2);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      wrap_up();
   end
   initial begin
      resetn = 1'b0; cmd_wr = 1'b0; cmd_rd = 1'b0; cmd_code = 8'h00; cmd_wdata = 16'h0000;
      vout_sense = 16'h03E8; vout_target = 16'h03E8; vout_relative = 1'b1;
      output_enabled = 1'b1; clear_faults = 1'b0;
      step(5);
      resetn = 1'b1;
      step(1);
      t_regs();
      t_limits();
      t_warn();
      t_latch();
      t_retry();
      t_ignore();
      wrap_up();
   end
endmodule // output_undervoltage_monitor_tb_top

// ===== testbench/ouv_stage_model.sv
// power stage stand-in: switching tick and soft-start ramp completion
// assumes shutdown_req and restart_req come from the monitor on sys_clk
`timescale 1ns/1ps
module ouv_stage_model #(
   parameter int TICK_DIV  = 4,
   parameter int RAMP_CLKS = 10
) (
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic restart_req,
   input  wire logic shutdown_req,
   output logic      pwm_tick,
   output logic      soft_start_done
);
   int div_q;
   int ramp_q;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         div_q           <= 0;
         ramp_q          <= 0;
         pwm_tick        <= 1'b0;
         soft_start_done <= 1'b0;
      end else begin
         div_q    <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
         pwm_tick <= (div_q == TICK_DIV - 1);
         // ramp done holds as a level until the next shutdown drops it
         if (restart_req) begin
            ramp_q          <= RAMP_CLKS;
            soft_start_done <= 1'b0;
         end else if (ramp_q > 1) begin
            ramp_q <= ramp_q - 1;
         end else if (ramp_q == 1) begin
            ramp_q          <= 0;
            soft_start_done <= 1'b1;
         end
         if (shutdown_req) begin
            soft_start_done <= 1'b0;
         end
      end
   end
endmodule // ouv_stage_model
